// ===== rtl/stop_pkg.sv
// Constants, types and decode functions shared by the stop sequence selector.
package stop_pkg;

  // ----------------------------------------------------------------
  // Widths, reset values and encodings
  // ----------------------------------------------------------------
  localparam int SPEED_W = 16;
  localparam int FORCE_W = 9;
  localparam int ERR_W   = 32;
  localparam int DELTA_W = 16;

  localparam logic [1:0] LIM_MODE_DIR   = 2'h0;
  localparam logic [1:0] LIM_MODE_OFF   = 2'h1;
  localparam logic [1:0] LIM_MODE_ALARM = 2'h2;
  localparam logic [1:0] LIM_MODE_RST   = 2'h1;

  localparam logic [1:0] LIM_ACT_BRAKE = 2'h0;
  localparam logic [1:0] LIM_ACT_ZERO  = 2'h1;
  localparam logic [1:0] LIM_ACT_IMM   = 2'h2;
  localparam logic [1:0] LIM_ACT_RST   = 2'h0;

  localparam logic [3:0] CODE_IMM_BRAKE  = 4'h8;
  localparam logic [3:0] CODE_IMM_UNLOCK = 4'h9;
  localparam logic [3:0] STOP_CODE_RST   = 4'h0;
  localparam logic [2:0] ALARM_ACT_RST   = 3'h0;
  localparam logic       UV_SEL_RST      = 1'h1;

  localparam logic [SPEED_W-1:0] STOP_SPEED_MMS = 16'h001E;
  localparam logic [ERR_W-1:0]   OVF_LIMIT_DEF  = 32'h0010_0000;

  typedef enum logic [2:0] {
    SRC_NONE  = 3'b000,
    SRC_LIMIT = 3'b001,
    SRC_SERVO = 3'b010,
    SRC_MAINS = 3'b011,
    SRC_ALARM = 3'b100
  } src_type;

  typedef struct packed {
    logic imm;
    logic free_run;
    logic unlock;
    logic hold;
  } stop_act_type;

  // Servo-off and mains-off codes; unknown codes fall back to code zero.
  function automatic stop_act_type decode_stop_code(input logic [3:0] c);
    stop_act_type a;
    a = '0;
    if (c == CODE_IMM_BRAKE || c == CODE_IMM_UNLOCK) begin
      a.imm    = 1'b1;
      a.unlock = c[0];
    end else if (c < CODE_IMM_BRAKE) begin
      a.free_run = c[0];
      a.unlock   = c[1];
      a.hold     = c[2];
    end
    return a;
  endfunction

  // Alarm codes always clear; bit2 asks for an immediate stop first.
  function automatic stop_act_type decode_alarm_code(input logic [2:0] c);
    stop_act_type a;
    a          = '0;
    a.imm      = c[2];
    a.free_run = c[0];
    a.unlock   = c[1];
    return a;
  endfunction

endpackage

// ===== rtl/err_if.sv
// Interface between the stop selector and its position error counter.
`timescale 1ns/1ps
interface err_if;
  logic                                 clear;
  logic signed [stop_pkg::DELTA_W-1:0]  cmd_delta;
  logic signed [stop_pkg::DELTA_W-1:0]  fb_delta;
  logic signed [stop_pkg::DELTA_W-1:0]  scale_delta;
  logic signed [stop_pkg::ERR_W-1:0]    pos_error;
  logic signed [stop_pkg::ERR_W-1:0]    scale_error;
  logic                                 overflow;

  modport ctrl (output clear, cmd_delta, fb_delta, scale_delta,
                input  pos_error, scale_error, overflow);
  modport counter (input  clear, cmd_delta, fb_delta, scale_delta,
                   output pos_error, scale_error, overflow);
endinterface

// ===== rtl/err_counter.sv
// Position error and external scale error accumulators with overflow detect.
`timescale 1ns/1ps
module err_counter #(
  parameter logic [stop_pkg::ERR_W-1:0] OVF_LIMIT = stop_pkg::OVF_LIMIT_DEF
) (
  input wire logic mclk,
  input wire logic rst_n,
  err_if.counter   eif
);
  localparam int W = stop_pkg::ERR_W;

  logic [W-1:0] pos_mag;

  // Magnitude of the position error for the overflow compare.
  assign pos_mag = eif.pos_error[W-1] ? W'(-eif.pos_error) : W'(eif.pos_error);

  // Clear wins; otherwise both errors keep accumulating.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      eif.pos_error   <= '0;
      eif.scale_error <= '0;
    end else if (eif.clear) begin
      eif.pos_error   <= '0;
      eif.scale_error <= '0;
    end else begin
      eif.pos_error   <= eif.pos_error + W'(eif.cmd_delta) - W'(eif.fb_delta);
      eif.scale_error <= eif.scale_error + W'(eif.scale_delta);
    end
  end

  // Overflow flag follows the magnitude, dropped while clearing.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      eif.overflow <= 1'b0;
    end else begin
      eif.overflow <= !eif.clear && (pos_mag > OVF_LIMIT);
    end
  end
endmodule

// ===== rtl/stop_phase.sv
// Tracks the slowing and stopped phases of one stop sequence.
`timescale 1ns/1ps
module stop_phase (
  input  wire logic                         mclk,
  input  wire logic                         rst_n,
  input  wire logic                         active,
  input  wire logic [stop_pkg::SPEED_W-1:0] speed_mms,
  output logic                              stopped
);
  typedef enum logic [1:0] {
    PH_IDLE    = 2'b00,
    PH_DECEL   = 2'b01,
    PH_STOPPED = 2'b10
  } phase_type;

  phase_type phase;
  phase_type next_phase;

  // Once the threshold is met the phase never returns to slowing.
  always_comb begin
    next_phase = phase;
    unique case (phase)
      PH_IDLE: begin
        if (active) begin
          next_phase = PH_DECEL;
        end
      end
      PH_DECEL: begin
        if (!active) begin
          next_phase = PH_IDLE;
        end else if (speed_mms <= stop_pkg::STOP_SPEED_MMS) begin
          next_phase = PH_STOPPED;
        end
      end
      PH_STOPPED: begin
        if (!active) begin
          next_phase = PH_IDLE;
        end
      end
      default: begin
        next_phase = PH_IDLE;
      end
    endcase
  end

  // Phase register.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      phase <= PH_IDLE;
    end else begin
      phase <= next_phase;
    end
  end

  assign stopped = (phase == PH_STOPPED);
endmodule

// ===== rtl/drive_stop_sequence_select.sv
// Stop sequence selector for limit inputs, servo off, mains loss and alarms.
`timescale 1ns/1ps
module drive_stop_sequence_select #(
  parameter logic [stop_pkg::ERR_W-1:0] OVF_LIMIT = stop_pkg::OVF_LIMIT_DEF
) (
  input  wire logic                                mclk,
  input  wire logic                                rst_n,
  input  wire logic                                fwd_limit_inhibit_in,
  input  wire logic                                rev_limit_inhibit_in,
  input  wire logic                                servo_on_cmd,
  input  wire logic                                mains_ok,
  input  wire logic                                alarm_in,
  input  wire logic                                alarm_reset,
  input  wire logic [stop_pkg::SPEED_W-1:0]        speed_mms,
  input  wire logic signed [stop_pkg::DELTA_W-1:0] cmd_delta,
  input  wire logic signed [stop_pkg::DELTA_W-1:0] fb_delta,
  input  wire logic signed [stop_pkg::DELTA_W-1:0] scale_delta,
  input  wire logic [1:0]                          limit_input_mode,
  input  wire logic [1:0]                          limit_stop_action,
  input  wire logic [3:0]                          servo_off_stop_action,
  input  wire logic [3:0]                          mains_off_stop_action,
  input  wire logic                                undervoltage_trip_select,
  input  wire logic [2:0]                          alarm_stop_action,
  input  wire logic [stop_pkg::FORCE_W-1:0]        immediate_stop_force_limit,
  input  wire logic [stop_pkg::FORCE_W-1:0]        normal_force_limit,
  output logic                                     fwd_inhibit,
  output logic                                     rev_inhibit,
  output logic                                     dyn_brake,
  output logic                                     free_run,
  output logic                                     servo_unlock,
  output logic                                     imm_stop,
  output logic                                     zero_force_fwd,
  output logic                                     zero_force_rev,
  output logic [stop_pkg::FORCE_W-1:0]             force_limit,
  output logic                                     err_clear,
  output logic                                     stop_done,
  output logic                                     drive_prohibit_alarm,
  output logic                                     mains_undervoltage_alarm,
  output logic                                     position_error_overflow_alarm,
  output logic signed [stop_pkg::ERR_W-1:0]        pos_error,
  output logic signed [stop_pkg::ERR_W-1:0]        scale_error
);

  // ----------------------------------------------------------------
  // Captured settings
  // ----------------------------------------------------------------
  logic       cfg_loaded;
  logic [1:0] cfg_lim_mode;
  logic [1:0] cfg_lim_act;
  logic [3:0] cfg_servo_act;
  logic [3:0] cfg_mains_act;
  logic       cfg_uv_sel;
  logic [2:0] cfg_alarm_act;

  // Settings load once, on the first edge after reset release.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_loaded    <= 1'b0;
      cfg_lim_mode  <= stop_pkg::LIM_MODE_RST;
      cfg_lim_act   <= stop_pkg::LIM_ACT_RST;
      cfg_servo_act <= stop_pkg::STOP_CODE_RST;
      cfg_mains_act <= stop_pkg::STOP_CODE_RST;
      cfg_uv_sel    <= stop_pkg::UV_SEL_RST;
      cfg_alarm_act <= stop_pkg::ALARM_ACT_RST;
    end else if (!cfg_loaded) begin
      cfg_loaded    <= 1'b1;
      cfg_lim_mode  <= limit_input_mode;
      cfg_lim_act   <= limit_stop_action;
      cfg_servo_act <= servo_off_stop_action;
      cfg_mains_act <= mains_off_stop_action;
      cfg_uv_sel    <= undervoltage_trip_select;
      cfg_alarm_act <= alarm_stop_action;
    end
  end

  // ----------------------------------------------------------------
  // Limit inputs and alarms
  // ----------------------------------------------------------------
  logic fwd_open;
  logic rev_open;
  logic fwd_blk;
  logic rev_blk;
  logic prohibit_cond;
  logic mains_prev;
  logic uv_set;
  logic alarm_any;
  err_if eif ();

  // An input closed to its common return reads high and restricts nothing.
  assign fwd_open = cfg_loaded && !fwd_limit_inhibit_in;
  assign rev_open = cfg_loaded && !rev_limit_inhibit_in;

  // Direction blocking in the modes that honour the inputs.
  assign fwd_blk = fwd_open && (cfg_lim_mode != stop_pkg::LIM_MODE_OFF);
  assign rev_blk = rev_open && (cfg_lim_mode != stop_pkg::LIM_MODE_OFF);

  // Drive prohibition alarm condition per limit input mode.
  assign prohibit_cond =
    ((cfg_lim_mode == stop_pkg::LIM_MODE_DIR) && fwd_open && rev_open) ||
    ((cfg_lim_mode == stop_pkg::LIM_MODE_ALARM) && (fwd_open || rev_open));

  // Mains loss seen while the servo is on trips when selected.
  assign uv_set = cfg_loaded && mains_prev && !mains_ok && servo_on_cmd && cfg_uv_sel;

  assign alarm_any = alarm_in || drive_prohibit_alarm || mains_undervoltage_alarm ||
                     position_error_overflow_alarm;

  // Mains level of the previous cycle for the loss edge.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mains_prev <= 1'b1;
    end else begin
      mains_prev <= mains_ok;
    end
  end

  // Sticky alarms; a new set wins over a simultaneous reset.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      drive_prohibit_alarm          <= 1'b0;
      mains_undervoltage_alarm      <= 1'b0;
      position_error_overflow_alarm <= 1'b0;
    end else begin
      drive_prohibit_alarm <= prohibit_cond ||
                              (drive_prohibit_alarm && !alarm_reset);
      mains_undervoltage_alarm <= uv_set ||
                                  (mains_undervoltage_alarm && !alarm_reset);
      position_error_overflow_alarm <= eif.overflow ||
                                       (position_error_overflow_alarm && !alarm_reset);
    end
  end

  // ----------------------------------------------------------------
  // Stop source and action selection
  // ----------------------------------------------------------------
  stop_pkg::src_type      src;
  stop_pkg::stop_act_type act;
  logic                   stopped;

  // Alarms outrank mains loss, which outranks servo off and limits.
  always_comb begin
    src = stop_pkg::SRC_NONE;
    if (!cfg_loaded) begin
      src = stop_pkg::SRC_NONE;
    end else if (alarm_any) begin
      src = stop_pkg::SRC_ALARM;
    end else if (!mains_ok) begin
      src = stop_pkg::SRC_MAINS;
    end else if (!servo_on_cmd) begin
      src = stop_pkg::SRC_SERVO;
    end else if ((fwd_blk || rev_blk) && cfg_lim_mode == stop_pkg::LIM_MODE_DIR) begin
      src = stop_pkg::SRC_LIMIT;
    end
  end

  // Decoded action for the winning source.
  always_comb begin
    unique case (src)
      stop_pkg::SRC_ALARM: act = stop_pkg::decode_alarm_code(cfg_alarm_act);
      stop_pkg::SRC_MAINS: act = stop_pkg::decode_stop_code(cfg_mains_act);
      stop_pkg::SRC_SERVO: act = stop_pkg::decode_stop_code(cfg_servo_act);
      stop_pkg::SRC_LIMIT: begin
        act      = '0;
        act.imm  = (cfg_lim_act == stop_pkg::LIM_ACT_IMM);
        act.hold = (cfg_lim_act != stop_pkg::LIM_ACT_IMM);
      end
      stop_pkg::SRC_NONE: act = '0;
      default: act = '0;
    endcase
  end

  stop_phase u_phase (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .active    (src != stop_pkg::SRC_NONE),
    .speed_mms (speed_mms),
    .stopped   (stopped)
  );

  // ----------------------------------------------------------------
  // Output commands
  // ----------------------------------------------------------------
  logic                         next_dyn_brake;
  logic                         next_free_run;
  logic                         next_unlock;
  logic                         next_imm;
  logic                         next_zero_fwd;
  logic                         next_zero_rev;
  logic                         next_err_clear;
  logic [stop_pkg::FORCE_W-1:0] next_force;

  // Braking method for slowing and after-stop phases.
  always_comb begin
    next_dyn_brake = 1'b0;
    next_free_run  = 1'b0;
    next_unlock    = 1'b0;
    next_imm       = 1'b0;
    next_zero_fwd  = 1'b0;
    next_zero_rev  = 1'b0;
    next_err_clear = (src != stop_pkg::SRC_NONE) && !act.hold;
    if (src == stop_pkg::SRC_LIMIT) begin
      next_zero_fwd = fwd_blk && (stopped || cfg_lim_act != stop_pkg::LIM_ACT_BRAKE);
      next_zero_rev = rev_blk && (stopped || cfg_lim_act != stop_pkg::LIM_ACT_BRAKE);
      next_dyn_brake = !stopped && (cfg_lim_act == stop_pkg::LIM_ACT_BRAKE);
      next_imm = !stopped && act.imm;
    end else if (src != stop_pkg::SRC_NONE) begin
      if (!stopped) begin
        next_imm       = act.imm;
        next_free_run  = !act.imm && act.free_run;
        next_dyn_brake = !act.imm && !act.free_run;
      end else begin
        next_unlock    = act.unlock;
        next_dyn_brake = !act.unlock;
      end
    end
  end

  // Immediate stop uses its own limit unless that limit is zero.
  always_comb begin
    next_force = normal_force_limit;
    if (next_imm && immediate_stop_force_limit != '0) begin
      next_force = immediate_stop_force_limit;
    end
  end

  // Registered drive commands.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      fwd_inhibit    <= 1'b0;
      rev_inhibit    <= 1'b0;
      dyn_brake      <= 1'b0;
      free_run       <= 1'b0;
      servo_unlock   <= 1'b0;
      imm_stop       <= 1'b0;
      zero_force_fwd <= 1'b0;
      zero_force_rev <= 1'b0;
      force_limit    <= '0;
      stop_done      <= 1'b0;
    end else begin
      fwd_inhibit    <= fwd_blk;
      rev_inhibit    <= rev_blk;
      dyn_brake      <= next_dyn_brake;
      free_run       <= next_free_run;
      servo_unlock   <= next_unlock;
      imm_stop       <= next_imm;
      zero_force_fwd <= next_zero_fwd;
      zero_force_rev <= next_zero_rev;
      force_limit    <= next_force;
      stop_done      <= stopped;
    end
  end

  // Clear request goes to the counter at the same edge as the output.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      err_clear <= 1'b0;
    end else begin
      err_clear <= next_err_clear;
    end
  end

  // ----------------------------------------------------------------
  // Error counter
  // ----------------------------------------------------------------
  assign eif.clear       = next_err_clear;
  assign eif.cmd_delta   = cmd_delta;
  assign eif.fb_delta    = fb_delta;
  assign eif.scale_delta = scale_delta;
  assign pos_error       = eif.pos_error;
  assign scale_error     = eif.scale_error;

  err_counter #(
    .OVF_LIMIT (OVF_LIMIT)
  ) u_err (
    .mclk  (mclk),
    .rst_n (rst_n),
    .eif   (eif)
  );

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  logic mode_dir;
  assign mode_dir = cfg_loaded && cfg_lim_mode == stop_pkg::LIM_MODE_DIR;

  sequence s_fwd_open_only;
    mode_dir && !fwd_limit_inhibit_in && rev_limit_inhibit_in;
  endsequence

  // Slow speed on two active cycles covers the idle to slowing step before stopping.
  sequence s_settle;
    (src != stop_pkg::SRC_NONE && speed_mms <= stop_pkg::STOP_SPEED_MMS) [*2] ##1
    (src != stop_pkg::SRC_NONE);
  endsequence

  property p_fwd_block;
    s_fwd_open_only |=> fwd_inhibit && !rev_inhibit;
  endproperty
  a_fwd_block: assert property (p_fwd_block) else $error("forward limit not blocking");

  property p_closed_free;
    cfg_loaded && fwd_limit_inhibit_in && rev_limit_inhibit_in |=>
      !fwd_inhibit && !rev_inhibit;
  endproperty
  a_closed_free: assert property (p_closed_free) else $error("closed limit restricts");

  property p_both_open;
    mode_dir && !fwd_limit_inhibit_in && !rev_limit_inhibit_in |=> drive_prohibit_alarm;
  endproperty
  a_both_open: assert property (p_both_open) else $error("no prohibit alarm, mode 0");

  property p_mode_alarm;
    cfg_loaded && cfg_lim_mode == stop_pkg::LIM_MODE_ALARM &&
      (!fwd_limit_inhibit_in || !rev_limit_inhibit_in) |=> drive_prohibit_alarm;
  endproperty
  a_mode_alarm: assert property (p_mode_alarm) else $error("no prohibit alarm, mode 2");

  property p_mode_off;
    cfg_loaded && cfg_lim_mode == stop_pkg::LIM_MODE_OFF |=> !fwd_inhibit && !rev_inhibit;
  endproperty
  a_mode_off: assert property (p_mode_off) else $error("limit honoured in mode 1");

  property p_imm_force;
    imm_stop |-> force_limit == ($past(immediate_stop_force_limit) != '0 ?
      $past(immediate_stop_force_limit) : $past(normal_force_limit));
  endproperty
  a_imm_force: assert property (p_imm_force) else $error("wrong stop force limit");

  property p_uv_trip;
    uv_set |=> mains_undervoltage_alarm ##1 (src == stop_pkg::SRC_ALARM);
  endproperty
  a_uv_trip: assert property (p_uv_trip) else $error("undervoltage not raised");

  property p_clear_zero;
    err_clear |-> pos_error == '0 && scale_error == '0;
  endproperty
  a_clear_zero: assert property (p_clear_zero) else $error("error not cleared");

  property p_settle;
    s_settle |-> stopped;
  endproperty
  a_settle: assert property (p_settle) else $error("stop not reached at threshold");

  property p_sticky;
    stopped && src != stop_pkg::SRC_NONE |=> stopped;
  endproperty
  a_sticky: assert property (p_sticky) else $error("after-stop state dropped");

endmodule

// ===== sim/motor_limit_model.sv
// Limit switches and a motor that coasts down while any stop output acts.
`timescale 1ns/1ps
module motor_limit_model (
  input  wire logic                         mclk,
  input  wire logic                         run,
  input  wire logic                         fwd_open,
  input  wire logic                         rev_open,
  input  wire logic                         braking,
  output logic                              fwd_limit_inhibit_in,
  output logic                              rev_limit_inhibit_in,
  output logic [stop_pkg::SPEED_W-1:0]      speed_mms
);
  // An opened switch breaks the path to the common return.
  assign fwd_limit_inhibit_in = !fwd_open;
  assign rev_limit_inhibit_in = !rev_open;
  // Speed is high while running and drops one step per braking cycle.
  always_ff @(posedge mclk) begin
    if (run)
      speed_mms <= 16'h0100;
    else if (braking && speed_mms > 16'h0020)
      speed_mms <= speed_mms - 16'h0020;
    else if (braking)
      speed_mms <= 16'h0000;
  end
endmodule

// ===== sim/drive_stop_sequence_select_tb_top.sv
// Self-checking bench for the stop sequence selector.
`timescale 1ns/1ps
module drive_stop_sequence_select_tb_top;
  logic mclk = 0, rst_n = 0, run = 1, fo = 0, ro = 0, alarm_reset = 0;
  logic servo_on_cmd = 1, mains_ok = 1, alarm_in = 0, undervoltage_trip_select = 0;
  logic [1:0] limit_input_mode = 0, limit_stop_action = 0;
  logic [3:0] servo_off_stop_action = 0, mains_off_stop_action = 0;
  logic [2:0] alarm_stop_action = 0;
  logic [8:0] immediate_stop_force_limit = 0, normal_force_limit = 9'h064;
  logic signed [15:0] cmd_delta = 0, fb_delta = 0, scale_delta = 0;
  logic fwd_limit_inhibit_in, rev_limit_inhibit_in, fwd_inhibit, rev_inhibit, dyn_brake;
  logic free_run, servo_unlock, imm_stop, zero_force_fwd, zero_force_rev, err_clear;
  logic stop_done, drive_prohibit_alarm, mains_undervoltage_alarm;
  logic position_error_overflow_alarm;
  logic [8:0] force_limit;
  logic [15:0] speed_mms;
  logic signed [31:0] pos_error, scale_error;
  logic [4:0] outs;
  int fail_count = 0, n_checks = 0;
  assign outs = {dyn_brake, free_run, servo_unlock, imm_stop, err_clear};
  // The clock runs at 40 MHz.
  always #12.5 mclk = !mclk;
  drive_stop_sequence_select #(.OVF_LIMIT(32'h0000_0064)) dut_u (.mclk, .rst_n,
    .fwd_limit_inhibit_in, .rev_limit_inhibit_in, .servo_on_cmd, .mains_ok, .alarm_in,
    .alarm_reset, .speed_mms, .cmd_delta, .fb_delta, .scale_delta, .limit_input_mode,
    .limit_stop_action, .servo_off_stop_action, .mains_off_stop_action,
    .undervoltage_trip_select, .alarm_stop_action, .immediate_stop_force_limit,
    .normal_force_limit, .fwd_inhibit, .rev_inhibit, .dyn_brake, .free_run, .servo_unlock,
    .imm_stop, .zero_force_fwd, .zero_force_rev, .force_limit, .err_clear, .stop_done,
    .drive_prohibit_alarm, .mains_undervoltage_alarm, .position_error_overflow_alarm,
    .pos_error, .scale_error);
  motor_limit_model model_u (.mclk, .run, .fwd_open(fo), .rev_open(ro),
    .braking(outs[4:1] != 0 || zero_force_fwd || zero_force_rev), .fwd_limit_inhibit_in,
    .rev_limit_inhibit_in, .speed_mms);
  // Ends the run with the verdict.
  task automatic results;
    if (fail_count == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #2;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Resets with fresh settings held stable across the release.
  task automatic boot(input logic [1:0] m, l, input logic [3:0] s, a, input logic [2:0] al);
    rst_n = 0;
    {limit_input_mode, limit_stop_action, servo_off_stop_action} = {m, l, s};
    {mains_off_stop_action, alarm_stop_action} = {a, al};
    {fo, ro, servo_on_cmd, mains_ok, alarm_in, run, cmd_delta} = {6'b001101, 16'h0000};
    {fb_delta, scale_delta} = 32'h0;
    tick(6);
    rst_n = 1;
    tick(3);
  endtask
  task automatic wait_done;
    int i;
    for (i = 0; i < 60 && stop_done !== 1'b1; i++) tick(1);
    if (i == 60) begin
      fail_count++;
      results();
    end
    tick(1);
  endtask
  // Expected {brake, free-run, unlock, immediate, clear} for a servo or mains code.
  function automatic logic [4:0] exp_code(input logic [3:0] c, input logic st);
    logic im, fr, ul, hd;
    im = c >= 8;
    fr = c < 8 && c[0];
    ul = im ? c[0] : c[1];
    hd = c >= 4 && c < 8;
    if (st) return {!ul, 1'b0, ul, 1'b0, !hd};
    return {!im && !fr, fr, 1'b0, im, !hd};
  endfunction
  // Main sequence of scenarios.
  initial begin
    for (int c = 0; c < 10; c++) begin
      boot(0, 0, c[3:0], 4'(9 - c), 0);
      {cmd_delta, scale_delta} = 32'h0001_0001;
      servo_on_cmd = 0;
      tick(3);
      chk(outs, exp_code(c[3:0], 0));
      mains_ok = 0;
      tick(3);
      chk(outs, exp_code(4'(9 - c), 0));
      run = 0;
      wait_done();
      chk(outs, exp_code(4'(9 - c), 1));
      if (c < 2 || c > 5) chk(pos_error | scale_error, 0);
      else chk({pos_error != 0, scale_error != 0}, 2'b11);
      run = 1;
      tick(4);
      chk(outs, exp_code(4'(9 - c), 1));
    end
    boot(0, 0, 0, 0, 0);
    fo = 1;
    tick(2);
    chk({fwd_inhibit, rev_inhibit, dyn_brake}, 3'b101);
    run = 0;
    wait_done();
    chk({zero_force_fwd, dyn_brake, err_clear}, 3'b100);
    {fo, ro} = 2'b01;
    tick(2);
    chk({fwd_inhibit, rev_inhibit}, 2'b01);
    ro = 0;
    tick(2);
    chk({fwd_inhibit, rev_inhibit}, 2'b00);
    {fo, ro} = 2'b11;
    tick(2);
    chk(drive_prohibit_alarm, 1);
    boot(0, 1, 0, 0, 0);
    ro = 1;
    tick(2);
    chk({zero_force_rev, dyn_brake, err_clear}, 3'b100);
    boot(0, 2, 0, 0, 0);
    immediate_stop_force_limit = 9'h032;
    fo = 1;
    tick(2);
    chk({imm_stop, err_clear, force_limit}, {2'b11, 9'h032});
    immediate_stop_force_limit = 0;
    tick(2);
    chk(force_limit, 9'h064);
    run = 0;
    wait_done();
    chk({zero_force_fwd, err_clear}, 2'b11);
    boot(1, 0, 4'h4, 0, 3'h4);
    {limit_input_mode, fo, ro} = 4'b0011;
    tick(2);
    chk({fwd_inhibit, rev_inhibit, drive_prohibit_alarm}, 0);
    servo_on_cmd = 0;
    {cmd_delta, fb_delta} = {16'sh0002, -16'sh0003};
    tick(8);
    chk({pos_error != 0, pos_error[31], err_clear}, 3'b100);
    tick(30);
    chk(position_error_overflow_alarm, 1);
    boot(1, 0, 4'h4, 0, 3'h4);
    servo_on_cmd = 0;
    alarm_in = 1;
    tick(3);
    chk({imm_stop, err_clear}, 2'b11);
    boot(2, 0, 0, 0, 0);
    ro = 1;
    tick(2);
    chk(drive_prohibit_alarm, 1);
    // An alarm reset loses to a cause that is still present, then clears it.
    alarm_reset = 1;
    tick(2);
    chk(drive_prohibit_alarm, 1);
    ro = 0;
    tick(2);
    chk(drive_prohibit_alarm, 0);
    alarm_reset = 0;
    undervoltage_trip_select = 1;
    boot(1, 0, 0, 0, 3'h3);
    mains_ok = 0;
    tick(3);
    chk({mains_undervoltage_alarm, free_run, err_clear}, 3'b111);
    results();
  end
endmodule
